// ### core/pll_ctr_pkg.sv
// Package for the oscillator divider and phase counter block.
// Holds register offsets, field positions, reset values and the mode encoding.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package pll_ctr_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_LOOP = 8'h04;
   localparam logic [7:0] OFS_OUT0 = 8'h08;
   localparam logic [7:0] OFS_OUT1 = 8'h0C;
   localparam logic [7:0] OFS_OUT2 = 8'h10;
   localparam logic [7:0] OFS_LOCK_COUNT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL_ENABLE = 0;
   localparam int CTL_LOOP_RESET = 1;
   localparam int CTL_MODE_LSB = 2;
   localparam int CTL_COMP_SEL_LSB = 4;
   localparam int LOOP_PRESCALE_LSB = 0;
   localparam int LOOP_MULT_LSB = 8;
   localparam int CFG_HIGH_LSB = 0;
   localparam int CFG_LOW_LSB = 8;
   localparam int CFG_TAP_LSB = 16;
   localparam int CFG_INIT_LSB = 24;
   localparam int ST_RAW_LOCK = 0;
   localparam int ST_GATED_LOCK = 1;
   localparam int ST_RUNNING = 2;
   localparam int IRQ_LOCK_GAINED = 0;
   localparam int IRQ_LOCK_LOST = 1;

   // ----------------------------------------------------------------
   // Limits, reset values, interrupt bit mask
   // ----------------------------------------------------------------
   localparam int PRESCALE_MAX = 4;
   localparam int MULT_MAX = 32;
   localparam int POST_MAX = 32;
   localparam int NUM_TAPS = 8;
   localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RST_LOOP = 32'h0000_0101;
   localparam logic [31:0] RST_OUT = 32'h0100_0101;
   localparam logic [31:0] RST_LOCK_COUNT = 32'h0000_0010;
   localparam logic [1:0] IRQ_BITS_MASK = 2'h3;

   // Feedback compensation modes
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_ZERO_DELAY,
      MODE_NO_COMP,
      MODE_SOURCE_SYNC
   } comp_mode_t;

endpackage

// ### core/div_cfg_if.sv
// Interface carrying one counter's programming from the register file to a divider.
// Assumes the register file drives it and one divider reads it.
`timescale 1ns/1ps
`default_nettype none
interface div_cfg_if;
   logic [5:0] high_half;   // High time in half oscillator cycles
   logic [5:0] low_half;    // Low time in half oscillator cycles
   logic [2:0] tap;         // Oscillator phase tap
   logic [5:0] initial_val; // Counter starting value S
   modport src (output high_half, output low_half, output tap, output initial_val);
   modport sink (input high_half, input low_half, input tap, input initial_val);
endinterface
`default_nettype wire

// ### core/phase_divider.sv
// One phase-tapped high/low counter with a programmable start delay.
// Assumes a free running three-bit phase ring: one oscillator cycle is eight clocks.
`timescale 1ns/1ps
`default_nettype none
module phase_divider (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_run,
   input wire logic [2:0] i_phase,
   div_cfg_if.sink cfg,
   output logic o_clk
);
   import pll_ctr_pkg::*;

   typedef enum logic [1:0] {DIV_IDLE, DIV_WAIT, DIV_HIGH, DIV_LOW} div_state_t;
   div_state_t state_reg;
   logic [6:0] cnt_reg;
   logic half_tick;

   // Half-cycle tick on the chosen tap and its opposite phase
   assign half_tick = (i_phase == cfg.tap) || (i_phase == (cfg.tap ^ 3'h4));

   // ----------------------------------------------------------------
   // Counter sequence
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst || !i_run) begin
         state_reg <= DIV_IDLE;
         cnt_reg <= 7'h00;
      end else begin
         case (state_reg)
            DIV_IDLE: begin
               // Start delay of S-1 oscillator cycles, counted in half cycles
               if (cfg.initial_val <= 6'h01) begin
                  state_reg <= DIV_HIGH;
                  cnt_reg <= {1'b0, cfg.high_half};
               end else begin
                  state_reg <= DIV_WAIT;
                  cnt_reg <= {cfg.initial_val - 6'h01, 1'b0};
               end
            end
            DIV_WAIT: begin
               if (half_tick) begin
                  if (cnt_reg <= 7'h01) begin
                     state_reg <= DIV_HIGH;
                     cnt_reg <= {1'b0, cfg.high_half};
                  end else begin
                     cnt_reg <= cnt_reg - 7'h01;
                  end
               end
            end
            DIV_HIGH: begin
               if (half_tick) begin
                  if (cnt_reg > 7'h01) begin
                     cnt_reg <= cnt_reg - 7'h01;
                  end else if (cfg.low_half == 6'h00) begin
                     cnt_reg <= {1'b0, cfg.high_half}; // Zero low time holds high
                  end else begin
                     state_reg <= DIV_LOW;
                     cnt_reg <= {1'b0, cfg.low_half};
                  end
               end
            end
            DIV_LOW: begin
               if (half_tick) begin
                  if (cnt_reg > 7'h01) begin
                     cnt_reg <= cnt_reg - 7'h01;
                  end else begin
                     state_reg <= DIV_HIGH;
                     cnt_reg <= {1'b0, cfg.high_half};
                  end
               end
            end
            default: begin
               state_reg <= DIV_IDLE;
               cnt_reg <= 7'h00;
            end
         endcase
      end
   end

   // Output straight from a flop, low outside the high phase
   always_ff @(posedge i_clock) begin
      if (!i_nrst || !i_run) begin
         o_clk <= 1'b0;
      end else begin
         o_clk <= (state_reg == DIV_HIGH);
      end
   end
endmodule
`default_nettype wire

// ### core/lock_gate.sv
// Gated lock counter: holds lock low for a programmed count of input clock transitions.
// Assumes a one-clock transition strobe from a synchronised reference input.
`timescale 1ns/1ps
`default_nettype none
module lock_gate #(
   parameter int COUNT_BITS = 20
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_run,
   input wire logic i_transition,
   input wire logic i_raw_lock,
   input wire logic [COUNT_BITS-1:0] i_target,
   output logic o_gated
);
   logic [COUNT_BITS-1:0] count_reg;
   logic done;

   assign done = (count_reg >= i_target);

   // Counter restarts whenever the loop is not running
   always_ff @(posedge i_clock) begin
      if (!i_nrst || !i_run) begin
         count_reg <= '0;
      end else if (i_transition && !done) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst || !i_run) begin
         o_gated <= 1'b0;
      end else begin
         o_gated <= done && i_raw_lock;
      end
   end
endmodule
`default_nettype wire

// ### core/pll_counters.sv
// Digital counter section of a clock synthesiser: prescale, feedback, three post-scale
// counters, fine and coarse phase shift, compensation mode, lock and a Wishbone slave.
// Assumes i_clock is the oscillator's tap clock: eight clocks make one oscillator cycle.
`timescale 1ns/1ps
`default_nettype none
module pll_counters #(
   parameter int NUM_OUT = 3,
   parameter int LOCK_BITS = 20
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_ref_clk,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic [NUM_OUT-1:0] o_global_clk,
   output logic o_ext_clk,
   output logic o_ref_tick,
   output logic o_locked,
   output logic o_gated_locked,
   output logic o_irq
);
   import pll_ctr_pkg::*;

   // Refuse widths the register map and mode decode cannot serve
   if (NUM_OUT != 3 || LOCK_BITS < 1 || LOCK_BITS > 32) begin : g_bad_cfg
      $error("pll_counters: unsupported NUM_OUT or LOCK_BITS");
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [31:0] control_reg;
   logic [31:0] loop_reg;
   logic [31:0] out_cfg_reg [NUM_OUT];
   logic [31:0] lock_count_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic access;
   logic wr;
   logic [1:0] irq_event;

   // Byte lane merge used by every writable register except the interrupt mask and status
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = din[b*8 +: 8];
         end
      end
      return res;
   endfunction

   assign access = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr = access && i_wb_we;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= access;
      end
   end

   // Control and configuration writes
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         control_reg <= RST_CONTROL;
         loop_reg <= RST_LOOP;
         lock_count_reg <= RST_LOCK_COUNT;
         irq_mask_reg <= 2'h0;
         for (int k = 0; k < NUM_OUT; k++) begin
            out_cfg_reg[k] <= RST_OUT;
         end
      end else if (wr) begin
         case (i_wb_adr)
            OFS_CONTROL: control_reg <= merge(control_reg, i_wb_dat, i_wb_sel);
            OFS_LOOP: loop_reg <= merge(loop_reg, i_wb_dat, i_wb_sel);
            OFS_OUT0: out_cfg_reg[0] <= merge(out_cfg_reg[0], i_wb_dat, i_wb_sel);
            OFS_OUT1: out_cfg_reg[1] <= merge(out_cfg_reg[1], i_wb_dat, i_wb_sel);
            OFS_OUT2: out_cfg_reg[2] <= merge(out_cfg_reg[2], i_wb_dat, i_wb_sel);
            OFS_LOCK_COUNT: lock_count_reg <= merge(lock_count_reg, i_wb_dat, i_wb_sel);
            OFS_IRQ_MASK: irq_mask_reg <= i_wb_sel[0] ? i_wb_dat[1:0] : irq_mask_reg;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Loop control and reference path
   // ----------------------------------------------------------------
   logic run;
   logic [2:0] phase_reg;
   logic ref_sync1_reg;
   logic ref_sync2_reg;
   logic ref_last_reg;
   logic ref_rise;
   logic ref_transition;
   logic [2:0] prescale_cnt_reg;
   logic [2:0] prescale;
   logic [5:0] mult;
   comp_mode_t mode;
   logic [1:0] comp_sel;

   assign run = control_reg[CTL_ENABLE] && !control_reg[CTL_LOOP_RESET];
   assign mode = comp_mode_t'(control_reg[CTL_MODE_LSB +: 2]);
   assign comp_sel = control_reg[CTL_COMP_SEL_LSB +: 2];
   // Out of range values clamp, so a bad write never stalls a counter
   assign prescale = (loop_reg[LOOP_PRESCALE_LSB +: 3] == 3'h0) ? 3'h1 :
                     (loop_reg[LOOP_PRESCALE_LSB +: 3] > 3'(PRESCALE_MAX)) ?
                     3'(PRESCALE_MAX) : loop_reg[LOOP_PRESCALE_LSB +: 3];
   assign mult = (loop_reg[LOOP_MULT_LSB +: 6] == 6'h00) ? 6'h01 :
                 (loop_reg[LOOP_MULT_LSB +: 6] > 6'(MULT_MAX)) ?
                 6'(MULT_MAX) : loop_reg[LOOP_MULT_LSB +: 6];

   // Free running phase ring: eight taps per oscillator cycle
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         phase_reg <= 3'h0;
      end else begin
         phase_reg <= phase_reg + 3'h1;
      end
   end

   // Reference pin crosses in through two flops before any edge logic
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ref_sync1_reg <= 1'b0;
         ref_sync2_reg <= 1'b0;
         ref_last_reg <= 1'b0;
      end else begin
         ref_sync1_reg <= i_ref_clk;
         ref_sync2_reg <= ref_sync1_reg;
         ref_last_reg <= ref_sync2_reg;
      end
   end

   assign ref_rise = ref_sync2_reg && !ref_last_reg;
   assign ref_transition = ref_sync2_reg != ref_last_reg;

   // Prescale divider: one reference tick per n input clock periods
   always_ff @(posedge i_clock) begin
      if (!i_nrst || !run) begin
         prescale_cnt_reg <= 3'h0;
         o_ref_tick <= 1'b0;
      end else begin
         o_ref_tick <= 1'b0;
         if (ref_rise) begin
            if (prescale_cnt_reg + 3'h1 >= prescale) begin
               prescale_cnt_reg <= 3'h0;
               o_ref_tick <= 1'b1;
            end else begin
               prescale_cnt_reg <= prescale_cnt_reg + 3'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Counters: three post-scale outputs and the feedback counter
   // ----------------------------------------------------------------
   div_cfg_if out_cfg[NUM_OUT] ();
   div_cfg_if fb_cfg ();
   logic [NUM_OUT-1:0] div_clk;
   logic fb_clk;
   logic fb_last_reg;
   logic [2:0] fb_tap;
   logic [5:0] fb_init;

   generate
      for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
         // High and low in half cycles give a duty step of 50% over the division
         assign out_cfg[g].high_half = out_cfg_reg[g][CFG_HIGH_LSB +: 6];
         assign out_cfg[g].low_half = out_cfg_reg[g][CFG_LOW_LSB +: 6];
         assign out_cfg[g].tap = out_cfg_reg[g][CFG_TAP_LSB +: 3];
         assign out_cfg[g].initial_val = out_cfg_reg[g][CFG_INIT_LSB +: 6];
         phase_divider u_div (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_run(run),
            .i_phase(phase_reg),
            .cfg(out_cfg[g]),
            .o_clk(div_clk[g])
         );
      end
   endgenerate

   // Feedback follows the compensated output's tap and start so that output aligns
   always_comb begin
      fb_tap = loop_reg[CFG_TAP_LSB +: 3];
      fb_init = loop_reg[CFG_INIT_LSB +: 6];
      case (mode)
         MODE_NORMAL: begin
            if (comp_sel < 2'(NUM_OUT)) begin
               fb_tap = out_cfg_reg[comp_sel][CFG_TAP_LSB +: 3];
               fb_init = out_cfg_reg[comp_sel][CFG_INIT_LSB +: 6];
            end
         end
         MODE_ZERO_DELAY: begin
            fb_tap = out_cfg_reg[2][CFG_TAP_LSB +: 3];
            fb_init = out_cfg_reg[2][CFG_INIT_LSB +: 6];
         end
         default: begin
            // No compensation and source synchronous keep the feedback's own phase
         end
      endcase
   end

   // Feedback period is m oscillator cycles: m half cycles high, m low
   assign fb_cfg.high_half = mult;
   assign fb_cfg.low_half = mult;
   assign fb_cfg.tap = fb_tap;
   assign fb_cfg.initial_val = fb_init;

   phase_divider u_fb (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_run(run),
      .i_phase(phase_reg),
      .cfg(fb_cfg),
      .o_clk(fb_clk)
   );

   // Outputs leave through flops; the third feeds global and the pin together
   always_ff @(posedge i_clock) begin
      if (!i_nrst || !run) begin
         o_global_clk <= '0;
         o_ext_clk <= 1'b0;
      end else begin
         o_global_clk <= div_clk;
         o_ext_clk <= div_clk[2];
      end
   end

   // ----------------------------------------------------------------
   // Lock detection: exactly one feedback edge per reference tick
   // ----------------------------------------------------------------
   logic [1:0] fb_count_reg;
   logic gated_last_reg;
   logic gated;

   always_ff @(posedge i_clock) begin
      if (!i_nrst || !run) begin
         fb_last_reg <= 1'b0;
         fb_count_reg <= 2'h0;
         o_locked <= 1'b0;
      end else begin
         fb_last_reg <= fb_clk;
         if (o_ref_tick) begin
            o_locked <= (fb_count_reg == 2'h1);
            fb_count_reg <= (fb_clk && !fb_last_reg) ? 2'h1 : 2'h0;
         end else if (fb_clk && !fb_last_reg && fb_count_reg != 2'h3) begin
            fb_count_reg <= fb_count_reg + 2'h1;
         end
      end
   end

   lock_gate #(.COUNT_BITS(LOCK_BITS)) u_lock (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_run(run),
      .i_transition(ref_transition),
      .i_raw_lock(o_locked),
      .i_target(lock_count_reg[LOCK_BITS-1:0]),
      .o_gated(gated)
   );

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_gated_locked <= 1'b0;
         gated_last_reg <= 1'b0;
      end else begin
         o_gated_locked <= gated;
         gated_last_reg <= gated;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: sticky, write one to clear, set beats clear
   // ----------------------------------------------------------------
   assign irq_event = {gated_last_reg && !gated, gated && !gated_last_reg};

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         irq_status_reg <= 2'h0;
      end else if (wr && i_wb_adr == OFS_IRQ_STATUS && i_wb_sel[0]) begin
         irq_status_reg <= (irq_status_reg & ~i_wb_dat[1:0]) | irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_reg & irq_mask_reg & IRQ_BITS_MASK);
      end
   end

   // Read data registered with the ack; unmapped offsets read zero
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (access && !i_wb_we) begin
         case (i_wb_adr)
            OFS_CONTROL: o_wb_dat <= {26'h0, control_reg[5:0]};
            OFS_LOOP: o_wb_dat <= loop_reg & 32'h3F07_3F07;
            OFS_OUT0: o_wb_dat <= out_cfg_reg[0] & 32'h3F07_3F3F;
            OFS_OUT1: o_wb_dat <= out_cfg_reg[1] & 32'h3F07_3F3F;
            OFS_OUT2: o_wb_dat <= out_cfg_reg[2] & 32'h3F07_3F3F;
            OFS_LOCK_COUNT: o_wb_dat <= {12'h000, lock_count_reg[19:0]};
            OFS_STATUS: o_wb_dat <= {29'h0, run, o_gated_locked, o_locked};
            OFS_IRQ_STATUS: o_wb_dat <= {30'h0, irq_status_reg};
            OFS_IRQ_MASK: o_wb_dat <= {30'h0, irq_mask_reg};
            default: o_wb_dat <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### verif/ref_clock_src.sv
// Reference clock pin model feeding the counter block.
// Assumes a 1 ns unit; the 7 ns offset keeps edges off the bench clock.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_src #(
   parameter int HALF_NS = 640
) (
   input wire logic i_run,
   output logic o_ref
);
   // Toggles only while running; the pin stands low otherwise
   initial begin
      o_ref = 1'b0;
      #7;
      forever begin
         #(HALF_NS);
         o_ref = i_run ? ~o_ref : 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### verif/pll_counters_sva.sv
// Assertions for the counter block, bound to its top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pll_counters_chk #(
   parameter int NUM_OUT = 3
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [NUM_OUT-1:0] o_global_clk,
   input wire logic o_ext_clk,
   input wire logic o_ref_tick,
   input wire logic o_locked,
   input wire logic o_gated_locked,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);
   // Bus: one ack pulse a cycle after the request, data steady otherwise
   chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("no ack after request");
   chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack too long");
   chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   chk_data_hold: assert property (!o_wb_ack |-> $stable(o_wb_dat))
      else $error("read data moved without ack");
   // Pin copy and lock relations
   chk_pin_copy: assert property (o_ext_clk == o_global_clk[NUM_OUT-1])
      else $error("pin clock differs");
   chk_gate_raw: assert property (o_gated_locked |-> o_locked || $past(o_locked)
      || $past(o_locked, 2)) else $error("gated lock without lock");
   chk_tick_pulse: assert property (o_ref_tick |=> !o_ref_tick)
      else $error("tick too long");
   chk_lock_tick: assert property ($rose(o_locked) |-> o_ref_tick || $past(o_ref_tick)
      || $past(o_ref_tick, 2)) else $error("lock away from tick");
   // Reset must clear outputs, so this one is not disabled by it
   chk_reset_clear: assert property (disable iff (1'b0) !i_nrst |=> o_global_clk == '0
      && !o_locked && !o_gated_locked && !o_irq) else $error("outputs live in reset");
   cov_gated: cover property ($rose(o_gated_locked));
   cov_irq: cover property ($rose(o_irq));
   cov_pin: cover property ($rose(o_ext_clk));
endmodule
bind pll_counters pll_counters_chk #(.NUM_OUT(NUM_OUT)) u_chk (.i_clock(i_clock),
   .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .o_global_clk(o_global_clk), .o_ext_clk(o_ext_clk),
   .o_ref_tick(o_ref_tick), .o_locked(o_locked), .o_gated_locked(o_gated_locked),
   .o_irq(o_irq));
`default_nettype wire

// ### verif/pll_counters_tb.sv
// Bench for the counter block: registers, division, phase, lock, interrupts.
// Assumes package, interface, design, checker and reference model compiled first.
`timescale 1ns/1ps
`default_nettype none
module pll_counters_tb;
   import pll_ctr_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
   logic i_clock, i_nrst, req, wen, ref_run, ref_clk, ack, ext, tick, lk, glk, irq;
   logic [7:0] adr;
   logic [31:0] wdat, dat, rd;
   logic [2:0] gclk, pg;
   int error_cnt, comparisons, h, l, f[3], r[3];
   int exp_q[$];
   logic [7:0] ra[10] = '{OFS_CONTROL, OFS_LOOP, OFS_OUT0, OFS_OUT1, OFS_OUT2,
      OFS_LOCK_COUNT, OFS_STATUS, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h24};
   logic [31:0] rv[10] = '{RST_CONTROL, RST_LOOP, RST_OUT, RST_OUT, RST_OUT,
      RST_LOCK_COUNT, 32'h0, 32'h0, 32'h0, 32'h0};
   pll_counters u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_ref_clk(ref_clk),
      .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(wen), .i_wb_adr(adr), .i_wb_sel(4'hF),
      .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack), .o_global_clk(gclk),
      .o_ext_clk(ext), .o_ref_tick(tick), .o_locked(lk), .o_gated_locked(glk), .o_irq(irq));
   ref_clock_src #(.HALF_NS(640)) u_ref (.i_run(ref_run), .o_ref(ref_clk));
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // One classic bus cycle; the answer is waited for, never assumed
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      req <= 1'b1;
      wen <= we;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clock);
      end while (ack !== 1'b1);
      rd = dat;
      req <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic cnt(input int k, input logic v, output int n);
      n = 0;
      while (gclk[k] === v && n < 600) begin
         @(posedge i_clock);
         n++;
      end
   endtask
   // One full high and low phase of output k against the model queue
   task automatic meas(input int k);
      int x, hi, lo, eh, el;
      cnt(k, 1'b1, x);
      cnt(k, 1'b0, x);
      cnt(k, 1'b1, hi);
      cnt(k, 1'b0, lo);
      // Pop once: the macro names its arguments twice
      eh = exp_q.pop_front();
      el = exp_q.pop_front();
      `CHK(hi, eh)
      `CHK(lo, el)
   endtask
   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      error_cnt++;
      end_sim();
   end
   initial begin
      {i_nrst, req, wen, ref_run, adr, wdat} = '0;
      error_cnt = 0;
      comparisons = 0;
      h = $urandom(32'hc1bc);
      repeat (20) @(posedge i_clock);
      i_nrst <= 1'b1;
      @(posedge i_clock);
      // Reset values, then again after writes to read-only and unmapped places
      repeat (2) begin
         foreach (ra[i]) begin
            wb(1'b0, ra[i], 32'h0);
            `CHK(rd, rv[i])
         end
         wb(1'b1, 8'h24, 32'hFFFF_FFFF);
         wb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
      end
      // Every mode with random high and low counts on all outputs
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, OFS_CONTROL, 32'h0);
         for (int k = 0; k < 3; k++) begin
            h = 1 + int'($urandom % 8);
            l = 1 + int'($urandom % 8);
            wb(1'b1, OFS_OUT0 + 8'(4 * k), 32'h0100_0000 | 32'(l << 8) | 32'(h));
            exp_q.push_back(4 * h);
            exp_q.push_back(4 * l);
         end
         wb(1'b1, OFS_CONTROL, 32'(m << 2) | 32'h1);
         wb(1'b0, OFS_CONTROL, 32'h0);
         `CHK(rd[3:0], 4'(m << 2) | 4'h1)
         for (int k = 0; k < 3; k++) begin
            meas(k);
         end
      end
      // Tap 3 on output one, start value 3 on output two
      wb(1'b1, OFS_CONTROL, 32'h0);
      wb(1'b1, OFS_OUT0, 32'h0100_0404);
      wb(1'b1, OFS_OUT1, 32'h0103_0404);
      wb(1'b1, OFS_OUT2, 32'h0300_0404);
      wb(1'b1, OFS_CONTROL, 32'h0000_0009);
      // First and last rising edge of each output in the window
      f = '{-1, -1, -1};
      pg = 3'b000;
      for (int i = 0; i < 300; i++) begin
         @(posedge i_clock);
         for (int k = 0; k < 3; k++) begin
            if (gclk[k] === 1'b1 && pg[k] === 1'b0) begin
               r[k] = i;
               if (f[k] < 0) begin
                  f[k] = i;
               end
            end
         end
         pg = gclk;
      end
      `CHK(((r[1] - r[0]) % 4 + 4) % 4, 3)
      `CHK(f[2] - f[0] >= 12 && f[2] - f[0] <= 16, 1'b1)
      `CHK(ext, gclk[2])
      // Loop reset parks outputs and drops the running flag
      wb(1'b1, OFS_CONTROL, 32'h0000_000B);
      repeat (3) @(posedge i_clock);
      `CHK(gclk, 3'b000)
      wb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[2], 1'b0)
      // Prescale 2, multiplier 16 against a 64-clock reference; gate of 40
      wb(1'b1, OFS_CONTROL, 32'h0);
      wb(1'b1, OFS_LOOP, 32'h0000_1002);
      wb(1'b1, OFS_LOCK_COUNT, 32'h0000_0028);
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      ref_run <= 1'b1;
      wb(1'b1, OFS_CONTROL, 32'h0000_0001);
      h = 0;
      l = 0;
      while (glk !== 1'b1 && h < 3000) begin
         @(posedge i_clock);
         h++;
         if (tick === 1'b1) begin
            if (l > 0) `CHK(h - l, 128)
            l = h;
         end
      end
      `CHK(h >= 1200 && h <= 1360, 1'b1)
      `CHK(lk, 1'b1)
      repeat (3) @(posedge i_clock);
      `CHK(irq, 1'b1)
      wb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
      repeat (2) @(posedge i_clock);
      `CHK(irq, 1'b0)
      // Disable clears lock; the loss flag stays hidden until unmasked
      wb(1'b1, OFS_CONTROL, 32'h0);
      repeat (3) @(posedge i_clock);
      `CHK({lk, glk, gclk, irq}, 6'b00_0000)
      wb(1'b0, OFS_IRQ_STATUS, 32'h0);
      `CHK(rd[1:0], 2'b10)
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
      repeat (2) @(posedge i_clock);
      `CHK(irq, 1'b1)
      end_sim();
   end
endmodule
`default_nettype wire
